/* core/ime_pkg.sv */
// Shared constants and types for the I2C master bus engine.
package ime_pkg;
    localparam int SYS_CLK_HZ = 250_000_000;
    localparam int SCL_DEF_HZ = 400_000;
    // Quarter SCL period in clock cycles, rounded up so SCL never runs fast
    localparam logic [15:0] QTR_DEF = 16'((SYS_CLK_HZ + 4 * SCL_DEF_HZ - 1) / (4 * SCL_DEF_HZ));
    localparam logic [6:0] SCAN_FIRST = 7'h08;
    localparam logic [6:0] SCAN_LAST = 7'h77;
    localparam logic [5:0] MADDR_BITS_DEF = 6'h08;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 16;
    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_INIT = 4'h1,
        CMD_DISABLE = 4'h2,
        CMD_START = 4'h3,
        CMD_STOP = 4'h4,
        CMD_READ = 4'h5,
        CMD_WRITE = 4'h6,
        CMD_READFROM = 4'h7,
        CMD_WRITETO = 4'h8,
        CMD_READMEM = 4'h9,
        CMD_WRITEMEM = 4'hA,
        CMD_SCAN = 4'hB
    } ime_cmd_type;
    typedef enum logic [3:0] {
        ST_OFF = 4'h0,
        ST_IDLE = 4'h1,
        ST_START = 4'h3,
        ST_ADDR = 4'h2,
        ST_MADDR = 4'h6,
        ST_RSTART = 4'h7,
        ST_RADDR = 4'h5,
        ST_LOAD = 4'h4,
        ST_WDATA = 4'hC,
        ST_RDATA = 4'hD,
        ST_STOP = 4'hF,
        ST_DONE = 4'hE
    } ime_state_type;
endpackage

/* core/ime_fifo.sv */
// Synchronous FIFO with registered full and empty flags.
`timescale 1ns/1ps
module ime_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, rp_r;
    logic [AW:0] cnt_r, cnt_nxt;
    logic full_r, empty_r, push, pop;
    assign push = in_valid_i && !full_r;
    assign pop = out_ready_i && !empty_r;
    assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            full_r <= 1'b0;
            empty_r <= 1'b1;
        end else begin
            if (push) wp_r <= wp_r + AW'(1);
            if (pop) rp_r <= rp_r + AW'(1);
            cnt_r <= cnt_nxt;
            full_r <= (cnt_nxt == (AW+1)'(DEPTH));
            empty_r <= (cnt_nxt == '0);
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (push) mem[wp_r] <= in_data_i;
    end
    assign in_ready_o = !full_r;
    assign out_valid_o = !empty_r;
    assign out_data_o = mem[rp_r];
endmodule // ime_fifo

/* core/ime_engine.sv */
// I2C master bus engine: command sequencer, SCL timing and open-drain pins.
`timescale 1ns/1ps
// Behaviour
// - Scan probes addresses 0x08 through 0x77 and reports every responder.
// - Scan sends write bit; present only if SDA low in ack slot.
// - START is SDA falling while SCL is high.
// - STOP is SDA rising while SCL is high.
// - Receive exactly the count; ACK every byte but the last.
// - Last byte gets NACK if option set, else ACK.
// - Write samples ack per byte, halts on NACK, counts ACKs.
// - Transaction read addresses target, takes count bytes, STOP only if enabled.
// - Transaction write drops remaining payload after a NACK, returns ACK count.
// - With stop enabled a transaction write ends in STOP even after NACK.
// - Memory accesses carry target address and internal memory address.
// - Memory address width selectable in bits, default 8.
// - SCL rate programmable as a maximum, default 400 kHz, never exceeded.
// - Disable releases SCL and SDA until initialised again.
// - Target addresses are 7 bits followed by the direction bit.
module ime_engine (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Command
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic [3:0] cmd_code_i,
    input wire logic [6:0] cmd_addr_i,
    input wire logic [31:0] cmd_memaddr_i,
    input wire logic [5:0] cmd_addrsize_i,
    input wire logic [15:0] cmd_count_i,
    input wire logic cmd_nack_i,
    input wire logic cmd_stop_i,
    input wire logic [15:0] scl_quarter_i,
    // Status
    output logic done_o,
    output logic enabled_o,
    output logic nack_seen_o,
    output logic [15:0] ack_count_o,
    // Write data
    input wire logic [7:0] wr_data_i,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    // Read data and scan results
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    // Bus pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);
    ime_pkg::ime_state_type state_r, fin_st;
    ime_pkg::ime_cmd_type cmd_r;
    logic [1:0] ph_r, mb_r;
    logic [3:0] bit_r;
    logic [7:0] shift_r, push_data;
    logic [15:0] cnt_r, acks_r, qtr_r, qcnt_r;
    logic [6:0] addr_r, mbw;
    logic [31:0] maddr_r;
    logic [2:0] mbytes;
    logic scan_r, stop_r, nack_r, nack_seen_r, en_r, done_r, cmd_ready_r, wr_ready_r, ack_r;
    logic scl_oe_r, sda_oe_r, pin_lvl_r, scl_m_r, scl_s_r, sda_m_r, sda_s_r;
    logic tick, slot_st, byte_st, rx_st, start_st, stretch, need_push, stall;
    logic adv, byte_adv, fifo_ready, ack_drv, accept, is_mem;

    assign start_st = (state_r == ime_pkg::ST_START) || (state_r == ime_pkg::ST_RSTART);
    assign rx_st = (state_r == ime_pkg::ST_RDATA);
    assign byte_st = (state_r == ime_pkg::ST_ADDR) || (state_r == ime_pkg::ST_MADDR) ||
                     (state_r == ime_pkg::ST_RADDR) || (state_r == ime_pkg::ST_WDATA) || rx_st;
    assign slot_st = byte_st || start_st || (state_r == ime_pkg::ST_STOP);
    assign tick = (qcnt_r == qtr_r - 16'h0001);
    // Clock stretching: a target holding SCL low delays the sample phase
    assign stretch = byte_st && (ph_r == 2'h2) && !scl_s_r;
    assign need_push = rx_st || ((state_r == ime_pkg::ST_ADDR) && scan_r && !ack_r);
    // A full result FIFO holds SCL high in the ack slot rather than losing a byte
    assign stall = tick && byte_st && (ph_r == 2'h3) && (bit_r == 4'h8) && need_push && !fifo_ready;
    assign adv = tick && slot_st && !stretch && !stall;
    assign byte_adv = adv && byte_st && (ph_r == 2'h3) && (bit_r == 4'h8);
    assign push_data = rx_st ? shift_r : {1'b0, addr_r};
    assign ack_drv = (cnt_r != 16'h0001) || !nack_r;
    assign fin_st = stop_r ? ime_pkg::ST_STOP : ime_pkg::ST_DONE;
    assign accept = cmd_valid_i && cmd_ready_r &&
                    ((state_r == ime_pkg::ST_IDLE) || (cmd_code_i == ime_pkg::CMD_INIT));
    assign is_mem = (cmd_code_i == ime_pkg::CMD_READMEM) || (cmd_code_i == ime_pkg::CMD_WRITEMEM);
    assign mbw = 7'(cmd_addrsize_i) + 7'h07;
    // Zero width falls back to the default single byte; widths cap at four bytes
    assign mbytes = (cmd_addrsize_i == 6'h00) ? 3'(ime_pkg::MADDR_BITS_DEF >> 3) :
                    (mbw[6:3] > 4'h4) ? 3'h4 : mbw[5:3];

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            pin_lvl_r <= 1'b0;
        end else begin
            scl_m_r <= scl_i;
            scl_s_r <= scl_m_r;
            sda_m_r <= sda_i;
            sda_s_r <= sda_m_r;
            pin_lvl_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            qcnt_r <= 16'h0000;
        end else if (!slot_st || tick) begin
            qcnt_r <= 16'h0000;
        end else begin
            qcnt_r <= qcnt_r + 16'h0001;
        end
    end

    // Only pulls low or releases; the wire level comes from the pull-ups
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (state_r == ime_pkg::ST_OFF) begin
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (adv) begin
            case (ph_r)
                2'h0: begin
                    if (start_st) begin
                        sda_oe_r <= 1'b0;
                    end else if (byte_st) begin
                        scl_oe_r <= 1'b1;
                        sda_oe_r <= (bit_r == 4'h8) ? (rx_st && ack_drv) : (!rx_st && !shift_r[7]);
                    end else begin
                        scl_oe_r <= 1'b1;
                    end
                end
                2'h1: begin
                    if (state_r == ime_pkg::ST_STOP) sda_oe_r <= 1'b1;
                    else scl_oe_r <= 1'b0;
                end
                2'h2: begin
                    if (start_st) sda_oe_r <= 1'b1;
                    else if (state_r == ime_pkg::ST_STOP) scl_oe_r <= 1'b0;
                end
                default: begin
                    if (state_r == ime_pkg::ST_STOP) sda_oe_r <= 1'b0;
                    else scl_oe_r <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= ime_pkg::ST_OFF;
            cmd_r <= ime_pkg::CMD_NOP;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            mb_r <= 2'h0;
            shift_r <= 8'h00;
            cnt_r <= 16'h0000;
            acks_r <= 16'h0000;
            qtr_r <= ime_pkg::QTR_DEF;
            addr_r <= 7'h00;
            maddr_r <= 32'h00000000;
            scan_r <= 1'b0;
            stop_r <= 1'b0;
            nack_r <= 1'b0;
            nack_seen_r <= 1'b0;
            ack_r <= 1'b0;
            en_r <= 1'b0;
            done_r <= 1'b0;
            cmd_ready_r <= 1'b1;
            wr_ready_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (adv) ph_r <= ph_r + 2'h1;
            if (adv && byte_st && (ph_r == 2'h2)) begin
                if (bit_r == 4'h8) ack_r <= sda_s_r;
                else shift_r <= {shift_r[6:0], sda_s_r};
            end
            if (adv && byte_st && (ph_r == 2'h3) && (bit_r != 4'h8)) bit_r <= bit_r + 4'h1;
            case (state_r)
                ime_pkg::ST_OFF, ime_pkg::ST_IDLE: begin
                    if (accept) begin
                        cmd_r <= ime_pkg::ime_cmd_type'(cmd_code_i);
                        ph_r <= 2'h0;
                        bit_r <= 4'h0;
                        cnt_r <= cmd_count_i;
                        acks_r <= 16'h0000;
                        nack_seen_r <= 1'b0;
                        nack_r <= cmd_nack_i;
                        stop_r <= is_mem || cmd_stop_i;
                        scan_r <= (cmd_code_i == ime_pkg::CMD_SCAN);
                        addr_r <= (cmd_code_i == ime_pkg::CMD_SCAN) ? ime_pkg::SCAN_FIRST : cmd_addr_i;
                        mb_r <= 2'(mbytes - 3'h1);
                        case (mbytes)
                            3'h1: maddr_r <= {cmd_memaddr_i[7:0], 24'h000000};
                            3'h2: maddr_r <= {cmd_memaddr_i[15:0], 16'h0000};
                            3'h3: maddr_r <= {cmd_memaddr_i[23:0], 8'h00};
                            default: maddr_r <= cmd_memaddr_i;
                        endcase
                        cmd_ready_r <= 1'b0;
                        case (cmd_code_i)
                            ime_pkg::CMD_INIT: begin
                                en_r <= 1'b1;
                                qtr_r <= (scl_quarter_i == 16'h0000) ? ime_pkg::QTR_DEF : scl_quarter_i;
                                state_r <= ime_pkg::ST_DONE;
                            end
                            ime_pkg::CMD_DISABLE: begin
                                en_r <= 1'b0;
                                done_r <= 1'b1;
                                cmd_ready_r <= 1'b1;
                                state_r <= ime_pkg::ST_OFF;
                            end
                            ime_pkg::CMD_START: state_r <= ime_pkg::ST_START;
                            ime_pkg::CMD_STOP: state_r <= ime_pkg::ST_STOP;
                            ime_pkg::CMD_READ: begin
                                stop_r <= 1'b0;
                                state_r <= (cmd_count_i == 16'h0000) ? ime_pkg::ST_DONE : ime_pkg::ST_RDATA;
                            end
                            ime_pkg::CMD_WRITE: begin
                                stop_r <= 1'b0;
                                state_r <= (cmd_count_i == 16'h0000) ? ime_pkg::ST_DONE : ime_pkg::ST_LOAD;
                            end
                            ime_pkg::CMD_READFROM, ime_pkg::CMD_WRITETO, ime_pkg::CMD_READMEM,
                            ime_pkg::CMD_WRITEMEM, ime_pkg::CMD_SCAN: state_r <= ime_pkg::ST_START;
                            default: state_r <= ime_pkg::ST_DONE;
                        endcase
                    end
                end
                ime_pkg::ST_START: begin
                    if (adv && (ph_r == 2'h3)) begin
                        state_r <= (cmd_r == ime_pkg::CMD_START) ? ime_pkg::ST_DONE : ime_pkg::ST_ADDR;
                        // Only a transaction read opens with the read direction bit
                        shift_r <= {addr_r, (cmd_r == ime_pkg::CMD_READFROM)};
                    end
                end
                ime_pkg::ST_RSTART: begin
                    if (adv && (ph_r == 2'h3)) begin
                        state_r <= ime_pkg::ST_RADDR;
                        shift_r <= {addr_r, 1'b1};
                    end
                end
                ime_pkg::ST_STOP: begin
                    if (adv && (ph_r == 2'h3)) begin
                        if (scan_r && (addr_r != ime_pkg::SCAN_LAST)) begin
                            addr_r <= addr_r + 7'h01;
                            state_r <= ime_pkg::ST_START;
                        end else begin
                            state_r <= ime_pkg::ST_DONE;
                        end
                    end
                end
                ime_pkg::ST_LOAD: begin
                    wr_ready_r <= 1'b1;
                    if (wr_ready_r && wr_valid_i) begin
                        wr_ready_r <= 1'b0;
                        shift_r <= wr_data_i;
                        state_r <= ime_pkg::ST_WDATA;
                    end
                end
                ime_pkg::ST_DONE: begin
                    done_r <= 1'b1;
                    cmd_ready_r <= 1'b1;
                    state_r <= ime_pkg::ST_IDLE;
                end
                default: begin
                    if (byte_adv) begin
                        bit_r <= 4'h0;
                        case (state_r)
                            ime_pkg::ST_ADDR: begin
                                if (scan_r) begin
                                    state_r <= ime_pkg::ST_STOP;
                                end else if (ack_r) begin
                                    nack_seen_r <= 1'b1;
                                    state_r <= fin_st;
                                end else if ((cmd_r == ime_pkg::CMD_READMEM) ||
                                             (cmd_r == ime_pkg::CMD_WRITEMEM)) begin
                                    state_r <= ime_pkg::ST_MADDR;
                                    shift_r <= maddr_r[31:24];
                                    maddr_r <= {maddr_r[23:0], 8'h00};
                                end else if (cnt_r == 16'h0000) begin
                                    state_r <= fin_st;
                                end else begin
                                    state_r <= (cmd_r == ime_pkg::CMD_WRITETO) ? ime_pkg::ST_LOAD :
                                               ime_pkg::ST_RDATA;
                                end
                            end
                            ime_pkg::ST_MADDR: begin
                                if (ack_r) begin
                                    nack_seen_r <= 1'b1;
                                    state_r <= fin_st;
                                end else if (mb_r != 2'h0) begin
                                    mb_r <= mb_r - 2'h1;
                                    shift_r <= maddr_r[31:24];
                                    maddr_r <= {maddr_r[23:0], 8'h00};
                                end else if (cmd_r == ime_pkg::CMD_READMEM) begin
                                    state_r <= ime_pkg::ST_RSTART;
                                end else begin
                                    state_r <= (cnt_r == 16'h0000) ? fin_st : ime_pkg::ST_LOAD;
                                end
                            end
                            ime_pkg::ST_RADDR: begin
                                if (ack_r) nack_seen_r <= 1'b1;
                                state_r <= (ack_r || (cnt_r == 16'h0000)) ? fin_st : ime_pkg::ST_RDATA;
                            end
                            ime_pkg::ST_WDATA: begin
                                if (ack_r) begin
                                    nack_seen_r <= 1'b1;
                                    state_r <= fin_st;
                                end else begin
                                    acks_r <= acks_r + 16'h0001;
                                    cnt_r <= cnt_r - 16'h0001;
                                    state_r <= (cnt_r == 16'h0001) ? fin_st : ime_pkg::ST_LOAD;
                                end
                            end
                            default: begin
                                cnt_r <= cnt_r - 16'h0001;
                                state_r <= (cnt_r == 16'h0001) ? fin_st : ime_pkg::ST_RDATA;
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    ime_fifo #(.WIDTH(ime_pkg::BYTE_W), .DEPTH(ime_pkg::FIFO_DEPTH)) u_rx_fifo (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .in_valid_i(byte_adv && need_push),
        .in_ready_o(fifo_ready),
        .in_data_i(push_data),
        .out_valid_o(rd_valid_o),
        .out_ready_i(rd_ready_i),
        .out_data_o(rd_data_o)
    );

    assign cmd_ready_o = cmd_ready_r;
    assign done_o = done_r;
    assign enabled_o = en_r;
    assign nack_seen_o = nack_seen_r;
    assign ack_count_o = acks_r;
    assign wr_ready_o = wr_ready_r;
    assign scl_o = pin_lvl_r;
    assign sda_o = pin_lvl_r;
    assign scl_oe_o = scl_oe_r;
    assign sda_oe_o = sda_oe_r;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    logic [16:0] hcnt_r;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) hcnt_r <= 17'h00000;
        else hcnt_r <= scl_oe_r ? 17'h00000 : hcnt_r + 17'h00001;
    end
    sequence s_wr_nack;
        (state_r == ime_pkg::ST_WDATA) && byte_adv && ack_r;
    endsequence
    sequence s_last_ack_bit;
        rx_st && adv && (ph_r == 2'h0) && (bit_r == 4'h8) && (cnt_r == 16'h0001);
    endsequence
    a_start_edge: assert property (start_st && adv && (ph_r == 2'h2) |=> sda_oe_r && !scl_oe_r ##1 !scl_oe_r)
        else $error("START not made with SCL high");
    a_stop_edge: assert property ((state_r == ime_pkg::ST_STOP) && adv && (ph_r == 2'h3) |=> !sda_oe_r && !scl_oe_r)
        else $error("STOP not made with SCL high");
    a_scan_range: assert property (scan_r && (state_r != ime_pkg::ST_IDLE) |-> (addr_r >= ime_pkg::SCAN_FIRST) && (addr_r <= ime_pkg::SCAN_LAST))
        else $error("scan address out of range");
    a_addr_wbit: assert property ((state_r == ime_pkg::ST_ADDR) && (bit_r == 4'h0) && (ph_r == 2'h0) &&
                                  (cmd_r != ime_pkg::CMD_READFROM) |-> shift_r == {addr_r, 1'b0})
        else $error("address byte lacks write bit");
    a_raddr_rbit: assert property ((state_r == ime_pkg::ST_RADDR) && (bit_r == 4'h0) && (ph_r == 2'h0)
                                   |-> shift_r == {addr_r, 1'b1})
        else $error("read address lacks read bit");
    a_rx_ack: assert property (rx_st && adv && (ph_r == 2'h0) && (bit_r == 4'h8) && (cnt_r != 16'h0001) |=> sda_oe_r)
        else $error("no ACK after non-final byte");
    a_final_nack: assert property (s_last_ack_bit |=> sda_oe_r == !nack_r)
        else $error("final acknowledge wrong");
    a_nack_halt: assert property (s_wr_nack |=> (state_r != ime_pkg::ST_LOAD) && $stable(acks_r))
        else $error("payload continued after NACK");
    a_nack_stop: assert property (s_wr_nack ##0 stop_r |=> (state_r == ime_pkg::ST_STOP) ##1 (state_r == ime_pkg::ST_STOP))
        else $error("no STOP after NACK");
    a_off_quiet: assert property ((state_r == ime_pkg::ST_OFF) |=> !scl_oe_r && !sda_oe_r)
        else $error("pins driven while disabled");
    a_scl_high: assert property ($rose(scl_oe_r) && $past(byte_st) |-> ($past(hcnt_r) + 17'h00001) >= {qtr_r, 1'b0})
        else $error("SCL high time too short");
endmodule // ime_engine

/* sim/ime_tgt_model.sv */
// Behavioural I2C target: acks its address, logs writes, returns a fixed read byte.
`timescale 1ns/1ps
module ime_tgt_model #(parameter logic [6:0] ADDR = 7'h50, parameter int NACK_AT = 100) (
    input wire logic scl_i, input wire logic sda_i, output logic sda_oe_o
);
    logic [7:0] sr, wq[$];
    logic adr_ph = 1'b0, rd = 1'b0, sel = 1'b0;
    int bits = 0, nwr = 0;
    initial sda_oe_o = 1'b0;
    // Wait 1 ns so a data change beside a falling SCL is not taken for START or STOP
    always @(sda_i) #1 if (scl_i) {bits, adr_ph, sel} = {32'h0, !sda_i, 1'b0};
    always @(posedge scl_i) begin
        if (bits < 8) sr = {sr[6:0], sda_i};
        if (bits == 8 && rd && !adr_ph && sda_i) sel = 1'b0;
        bits++;
    end
    always @(negedge scl_i) begin
        sda_oe_o = 1'b0;
        if (bits == 8 && adr_ph) begin
            {sel, rd, nwr, adr_ph} = {sr[7:1] == ADDR, sr[0], 32'h0, 1'b0};
            sda_oe_o = sel;
        end else if (bits == 8 && sel && !rd) begin
            wq.push_back(sr);
            sda_oe_o = (++nwr < NACK_AT);
        end else if (bits == 9) bits = 0;
        if (sel && rd && !adr_ph && bits < 8) sda_oe_o = ((8'hC3 << bits) & 8'h80) == 0;
    end
endmodule // ime_tgt_model

/* sim/tb_top.sv */
// Bench: command calls drive the engine against two targets on one bus.
`timescale 1ns/1ps
module tb_top;
    logic ref_clk_i = 1'b0;
    logic reset_i, cmd_valid_i, cmd_nack_i, cmd_stop_i, wr_valid_i, rd_ready_i;
    logic [3:0] cmd_code_i;
    logic [6:0] cmd_addr_i;
    logic [31:0] cmd_memaddr_i;
    logic [5:0] cmd_addrsize_i;
    logic [15:0] cmd_count_i, scl_quarter_i, ack_count_o;
    logic [7:0] wr_data_i, rd_data_o, rq[$];
    logic cmd_ready_o, done_o, enabled_o, nack_seen_o, wr_ready_o, rd_valid_o, oe0, oe1;
    logic scl_o, scl_oe_o, sda_o, sda_oe_o;
    int error_cnt = 0, check_count = 0;
    wire scl_i = !scl_oe_o;
    wire sda_i = !(sda_oe_o | oe0 | oe1);
    ime_engine dut (.*);
    ime_tgt_model #(.ADDR(7'h08), .NACK_AT(3)) t0 (.scl_i, .sda_i, .sda_oe_o(oe0));
    ime_tgt_model #(.ADDR(7'h77)) t1 (.scl_i, .sda_i, .sda_oe_o(oe1));
    initial forever #2 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        if (rd_valid_o && rd_ready_i) rq.push_back(rd_data_o);
        if (wr_valid_i && wr_ready_o) wr_data_i <= wr_data_i + 8'h01;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        error_cnt += int'(g !== e);
        if (g !== e) $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    endtask
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmd(input logic [3:0] c, input logic [6:0] a = 7'h0,
        input logic [31:0] m = 32'h0, input logic [15:0] n = 16'h0, input logic nk = 1'b0,
        input logic st = 1'b0);
        @(posedge ref_clk_i);
        {cmd_code_i, cmd_addr_i, cmd_memaddr_i, cmd_count_i} <= {c, a, m, n};
        {cmd_nack_i, cmd_stop_i, cmd_valid_i} <= {nk, st, 1'b1};
        @(posedge ref_clk_i);
        cmd_valid_i <= 1'b0;
        repeat (50000) if (done_o !== 1'b1) @(posedge ref_clk_i);
        chk("done", 16'h1, {15'h0, done_o});
        if (done_o !== 1'b1) end_sim;
        else repeat (20) @(posedge ref_clk_i);
    endtask
    initial begin
        {cmd_valid_i, cmd_nack_i, cmd_stop_i, cmd_code_i, cmd_addr_i, cmd_count_i} = '0;
        {cmd_memaddr_i, cmd_addrsize_i, wr_data_i, scl_quarter_i} = {38'h0, 8'h10, 16'h0004};
        {reset_i, wr_valid_i, rd_ready_i} = 3'b111;
        repeat (4) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        cmd(ime_pkg::CMD_INIT);
        cmd(ime_pkg::CMD_SCAN);
        chk("scan hits", 16'h2, 16'(rq.size()));
        chk("first hit", 16'h08, {8'h0, rq[0]});
        chk("last hit", 16'h77, {8'h0, rq[1]});
        $display("Test scan finished");
        cmd(ime_pkg::CMD_WRITETO, 7'h08, 32'h0, 16'h5, 1'b0, 1'b1);
        chk("ack count", 16'h2, ack_count_o);
        chk("bytes sent", 16'h3, 16'(t0.wq.size()));
        chk("bus idle", 16'h3, {14'h0, scl_i, sda_i});
        $display("Test write with nack finished");
        // Stall the read side so the FIFO fills and the engine must hold SCL
        {cmd_addrsize_i, rd_ready_i} <= {6'h10, 1'b0};
        fork
            cmd(ime_pkg::CMD_READMEM, 7'h77, 32'h1234, 16'h12, 1'b1);
            begin repeat (4000) @(posedge ref_clk_i); rd_ready_i <= 1'b1; end
        join
        chk("read count", 16'h14, 16'(rq.size()));
        chk("read byte", 16'hC3, {8'h0, rq[19]});
        chk("memory address", 16'h1234, {t1.wq[0], t1.wq[1]});
        $display("Test memory read finished");
        cmd(ime_pkg::CMD_READFROM, 7'h77, 32'h0, 16'h3, 1'b1, 1'b1);
        chk("read count", 16'h17, 16'(rq.size()));
        chk("read byte", 16'hC3, {8'h0, rq[20]});
        $display("Test transaction read finished");
        cmd(ime_pkg::CMD_DISABLE);
        chk("pins off", 16'h0, {13'h0, enabled_o, scl_oe_o, sda_oe_o});
        $display("Test disable finished");
        end_sim;
    end
endmodule // tb_top
